// *** rtl/idl_pkg.sv ***
// Shared constants for the ident-page lock link and its host
package idl_pkg;
  // Instruction codes; one code pair serves both page and lock access
  localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] READ_STATUS_CMD = 8'h05;
  localparam logic [7:0] WRITE_STATUS_CMD = 8'h01;
  localparam logic [7:0] READ_LOCK_STATE_CMD = 8'h83;
  localparam logic [7:0] LOCK_IDENT_PAGE_CMD = 8'h82;
  localparam logic [7:0] READ_IDENT_PAGE_CMD = READ_LOCK_STATE_CMD;
  localparam logic [7:0] WRITE_IDENT_PAGE_CMD = LOCK_IDENT_PAGE_CMD;
  // Address and data field positions
  localparam int ADDR_BIT_TEN = 10;
  localparam int LOCK_DATA_BIT = 1;
  localparam int LOCK_STATE_BIT = 0;
  // Status byte layout
  localparam int SR_BUSY_BIT = 0;
  localparam int SR_WEL_BIT = 1;
  localparam int SR_BP_LO_BIT = 2;
  localparam int SR_BP_HI_BIT = 3;
  localparam int SR_WD_BIT = 7;
  // Correction groups of four bytes, Hamming single-error code
  localparam int ECC_DATA_W = 32;
  localparam int ECC_CHECK_W = 6;
  localparam int ECC_CODE_W = 38;
  localparam int PAGE_GROUPS = 8;
  localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WRITE_CYCLE_TIME_NS = 5000000;
  localparam int WRITE_CYCLE_CLKS =
    (WRITE_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCK_HALF_CLKS = 16;
  // Host register map
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_ADDR_BIT = 8;
  localparam int CMD_DATA_BIT = 9;
  localparam int CMD_RD_LSB = 10;
  // Reset values
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
endpackage : idl_pkg

// *** rtl/idl_spi_if.sv ***
// SPI wires between the memory end and its host
`timescale 1ns/1ns
interface idl_spi_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;
  // Pull-up keeps an undriven data line high
  assign miso = miso_oe ? miso_o : 1'b1;
  modport dev(input cs_n, input sck, input mosi, output miso_o,
              output miso_oe);
  modport host(output cs_n, output sck, output mosi, input miso);
endinterface : idl_spi_if

// *** rtl/idl_eeprom_dev.sv ***
// SPI memory end: lock read, page lock, status and ECC ident page
//
// Chosen for the host: the register offsets and its APB slave port.
`timescale 1ns/1ns
// Notes on behaviour
// - Lock read sends opcode, address with bit ten
// - Lock read byte LSB shows lock state
// - Held select repeats the same lock byte
// - Select high ends read, output released
// - Lock read ignored during write cycle
// - Executed lock makes page permanently read-only
// - Lock sends opcode, address bit ten, data
// - Lock data byte needs bit one set
// - Lock runs only on byte-boundary deselect
// - Valid lock deselect starts timed write cycle
// - Lock dropped if busy, full protect, no enable
// - Instructions ignored until power-on reset done
// - Reset clears enable and busy, keeps protect
// - Host deselects and idles before power off
// - Output driven only while selected
// - Four-byte groups correct single bit errors
// - Byte write rewrites its whole group
// - Delivered page all FFh, protect bits zero
module idl_eeprom_dev
  import idl_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = WRITE_CYCLE_CLKS
) (
  input wire logic clk,
  input wire logic rstn,
  idl_spi_if.dev spi,
  output logic write_busy_flag,
  output logic ident_locked
);
  localparam int WCW = $clog2(WRITE_CYCLES + 1);

  typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_DIN, PH_DOUT, PH_SKIP}
    idl_phase_e;

  function automatic logic [ECC_CODE_W-1:0] ecc_encode(
    input logic [ECC_DATA_W-1:0] d);
    logic [ECC_CODE_W-1:0] cw;
    int j;
    cw = '0;
    j = 0;
    for (int i = 0; i < ECC_CODE_W; i++) begin
      if (((i + 1) & i) != 0) begin
        cw[i] = d[j];
        j++;
      end
    end
    for (int k = 0; k < ECC_CHECK_W; k++) begin
      for (int i = 0; i < ECC_CODE_W; i++) begin
        if ((((i + 1) >> k) & 1) == 1 && ((i + 1) & i) != 0) begin
          cw[(1 << k) - 1] ^= cw[i];
        end
      end
    end
    return cw;
  endfunction : ecc_encode

  function automatic logic [ECC_DATA_W-1:0] ecc_decode(
    input logic [ECC_CODE_W-1:0] cw_in);
    logic [ECC_CODE_W-1:0] cw;
    logic [ECC_CHECK_W-1:0] syn;
    logic [ECC_DATA_W-1:0] d;
    int j;
    cw = cw_in;
    syn = '0;
    d = '0;
    j = 0;
    for (int i = 0; i < ECC_CODE_W; i++) begin
      if (cw[i]) begin
        syn ^= ECC_CHECK_W'(i + 1);
      end
    end
    if (syn != '0 && int'(syn) <= ECC_CODE_W) begin
      cw[int'(syn) - 1] = ~cw[int'(syn) - 1];
    end
    for (int i = 0; i < ECC_CODE_W; i++) begin
      if (((i + 1) & i) != 0) begin
        d[j] = cw[i];
        j++;
      end
    end
    return d;
  endfunction : ecc_decode

  localparam logic [ECC_CODE_W-1:0] ECC_ERASED = ecc_encode(ERASED_WORD);

  // Nonvolatile state: no reset, power-on keeps it
  // delivered state
  logic [ECC_CODE_W-1:0] mem [PAGE_GROUPS] = '{default: ECC_ERASED};
  logic locked = 1'b0;
  logic [1:0] bp = 2'b00;
  logic status_write_disable = 1'b0;
  logic next_locked, next_status_write_disable;
  logic [1:0] next_bp;
  logic mem_we;
  logic [ECC_CODE_W-1:0] mem_wdata;

  logic [2:0] cs_sy, sck_sy, mosi_sy;
  logic cs_n_q, sck_q, mosi_q, next_cs_n_q, next_sck_q, next_mosi_q;
  idl_phase_e phase, next_phase;
  logic [7:0] op, sh, data_byte, tx, next_op, next_sh, next_data_byte;
  logic [7:0] next_tx;
  logic [2:0] bitcnt, obit, next_bitcnt, next_obit;
  logic [15:0] addr, next_addr;
  logic abyte, got_data, q_oe, write_enable_latch, busy;
  logic next_abyte, next_got_data, next_q_oe, next_wel, next_busy;
  logic [WCW-1:0] wcnt, next_wcnt;
  logic sck_rise, sck_fall, cs_rise;
  logic [7:0] full, status, out_byte;
  logic [ECC_DATA_W-1:0] grp, newg;

  // Three-stage synchronisers; only stages two and three are looked at
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cs_sy <= 3'h7;
      sck_sy <= 3'h0;
      mosi_sy <= 3'h0;
    end else begin
      cs_sy <= {cs_sy[1:0], spi.cs_n};
      sck_sy <= {sck_sy[1:0], spi.sck};
      mosi_sy <= {mosi_sy[1:0], spi.mosi};
    end
  end

  always_comb begin
    next_cs_n_q = (cs_sy[2] == cs_sy[1]) ? cs_sy[1] : cs_n_q;
    next_sck_q = (sck_sy[2] == sck_sy[1]) ? sck_sy[1] : sck_q;
    next_mosi_q = (mosi_sy[2] == mosi_sy[1]) ? mosi_sy[1] : mosi_q;
    sck_rise = next_sck_q && !sck_q;
    sck_fall = !next_sck_q && sck_q;
    cs_rise = next_cs_n_q && !cs_n_q;
    full = {sh[6:0], mosi_q};
    status = 8'h00;
    status[SR_BUSY_BIT] = busy;
    status[SR_WEL_BIT] = write_enable_latch;
    status[SR_BP_LO_BIT] = bp[0];
    status[SR_BP_HI_BIT] = bp[1];
    status[SR_WD_BIT] = status_write_disable;
    grp = ecc_decode(mem[addr[4:2]]);
    out_byte = grp[{addr[1:0], 3'b000} +: 8];
    if (op == READ_STATUS_CMD) begin
      out_byte = status;
    end else if (addr[ADDR_BIT_TEN]) begin
      out_byte = 8'h00;
      out_byte[LOCK_STATE_BIT] = locked;
    end
    newg = ecc_decode(mem[addr[4:2]]);
    newg[{addr[1:0], 3'b000} +: 8] = data_byte;
    mem_wdata = ecc_encode(newg);
    mem_we = 1'b0;
    next_locked = locked;
    next_bp = bp;
    next_status_write_disable = status_write_disable;
    next_phase = phase;
    next_op = op;
    next_sh = sh;
    next_data_byte = data_byte;
    next_tx = tx;
    next_bitcnt = bitcnt;
    next_obit = obit;
    next_addr = addr;
    next_abyte = abyte;
    next_got_data = got_data;
    next_q_oe = q_oe;
    next_wel = write_enable_latch;
    next_busy = busy;
    next_wcnt = wcnt;
    if (busy) begin
      next_wcnt = wcnt - 1'b1;
      if (wcnt == WCW'(1)) begin
        next_busy = 1'b0;
      end
    end
    if (cs_rise) begin
      next_q_oe = 1'b0;
      next_phase = PH_CMD;
      next_bitcnt = 3'h0;
      next_obit = 3'h0;
      next_abyte = 1'b0;
      next_got_data = 1'b0;
      if (phase == PH_DIN) begin
        next_wel = 1'b0;
      end
      if (phase == PH_DIN && bitcnt == 3'h0 && got_data && write_enable_latch
          && !busy) begin
        if (op == WRITE_STATUS_CMD) begin
          next_bp = {data_byte[SR_BP_HI_BIT], data_byte[SR_BP_LO_BIT]};
          next_status_write_disable = data_byte[SR_WD_BIT];
          next_busy = 1'b1;
          next_wcnt = WCW'(WRITE_CYCLES);
        end else if (addr[ADDR_BIT_TEN]) begin
          // lock with bit one, not fully protected
          if (data_byte[LOCK_DATA_BIT] && bp != 2'b11) begin
            next_locked = 1'b1;
            next_busy = 1'b1;
            next_wcnt = WCW'(WRITE_CYCLES);
          end
        end else if (!locked && bp != 2'b11) begin
          mem_we = 1'b1;
          next_busy = 1'b1;
          next_wcnt = WCW'(WRITE_CYCLES);
        end
      end
    end else if (!cs_n_q && sck_rise && phase != PH_DOUT
                 && phase != PH_SKIP) begin
      next_sh = full;
      next_bitcnt = bitcnt + 1'b1;
      if (bitcnt == 3'h7) begin
        case (phase)
          PH_CMD: begin
            next_op = full;
            case (full)
              WRITE_ENABLE_CMD: begin
                next_wel = !busy | write_enable_latch;
                next_phase = PH_SKIP;
              end
              READ_STATUS_CMD: next_phase = PH_DOUT;
              WRITE_STATUS_CMD: next_phase = busy ? PH_SKIP : PH_DIN;
              // busy device skips page and lock reads and writes
              READ_LOCK_STATE_CMD, LOCK_IDENT_PAGE_CMD: begin
                next_phase = busy ? PH_SKIP : PH_ADDR;
              end
              default: next_phase = PH_SKIP;
            endcase
          end
          PH_ADDR: begin
            next_addr = {addr[7:0], full};
            next_abyte = 1'b1;
            if (abyte) begin
              next_phase = (op == READ_LOCK_STATE_CMD) ? PH_DOUT : PH_DIN;
            end
          end
          PH_DIN: begin
            next_data_byte = full;
            next_got_data = 1'b1;
            if (got_data) begin
              next_addr = {addr[15:5], addr[4:0] + 5'h01};
            end
          end
          default: next_phase = phase;
        endcase
      end
    end else if (!cs_n_q && sck_fall && phase == PH_DOUT) begin
      // load a byte every eight falls while selected
      next_obit = obit + 1'b1;
      if (obit == 3'h0) begin
        next_tx = out_byte;
        next_q_oe = 1'b1;
        if (op == READ_IDENT_PAGE_CMD && !addr[ADDR_BIT_TEN]) begin
          next_addr = {addr[15:5], addr[4:0] + 5'h01};
        end
      end else begin
        next_tx = {tx[6:0], 1'b0};
      end
    end
  end

  // Nonvolatile bits survive reset
  always_ff @(posedge clk) begin
    locked <= next_locked;
    bp <= next_bp;
    status_write_disable <= next_status_write_disable;
    if (mem_we) begin
      mem[addr[4:2]] <= mem_wdata;
    end
  end

  // reset clears volatile state and ignores the bus
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cs_n_q <= 1'b1;
      sck_q <= 1'b0;
      mosi_q <= 1'b0;
      phase <= PH_CMD;
      op <= BYTE_RESET;
      sh <= BYTE_RESET;
      data_byte <= BYTE_RESET;
      tx <= BYTE_RESET;
      bitcnt <= 3'h0;
      obit <= 3'h0;
      addr <= ADDR_RESET;
      abyte <= 1'b0;
      got_data <= 1'b0;
      q_oe <= 1'b0;
      write_enable_latch <= 1'b0;
      busy <= 1'b0;
      wcnt <= '0;
    end else begin
      cs_n_q <= next_cs_n_q;
      sck_q <= next_sck_q;
      mosi_q <= next_mosi_q;
      phase <= next_phase;
      op <= next_op;
      sh <= next_sh;
      data_byte <= next_data_byte;
      tx <= next_tx;
      bitcnt <= next_bitcnt;
      obit <= next_obit;
      addr <= next_addr;
      abyte <= next_abyte;
      got_data <= next_got_data;
      q_oe <= next_q_oe;
      write_enable_latch <= next_wel;
      busy <= next_busy;
      wcnt <= next_wcnt;
    end
  end

  assign spi.miso_o = tx[7];
  assign spi.miso_oe = q_oe;
  assign write_busy_flag = busy;
  assign ident_locked = locked;
endmodule : idl_eeprom_dev

// *** rtl/idl_spi_host.sv ***
// SPI host end: APB registers drive one framed transfer at a time
`timescale 1ns/1ns
module idl_spi_host
  import idl_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  idl_spi_if.host spi
);
  typedef enum logic [1:0] {H_IDLE, H_RUN, H_TAIL, H_GAP} idl_hstate_e;

  idl_hstate_e hs, next_hs;
  logic [7:0] op, data_r, rx, rxsh, next_op, next_data_r, next_rx;
  logic [7:0] next_rxsh;
  logic [15:0] addr_r, next_addr_r;
  logic addr_en, data_en, next_addr_en, next_data_en;
  logic [2:0] rd_n, next_rd_n;
  logic [31:0] txsh, next_txsh, next_prdata;
  logic [6:0] nbits, bitcnt, next_nbits, next_bitcnt;
  logic [4:0] div, next_div;
  logic sck, cs_n, mosi, next_sck, next_cs_n, next_mosi;
  logic [2:0] miso_sy;
  logic miso_q, next_miso_q;
  logic wr, mapped, half;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      miso_sy <= 3'h7;
    end else begin
      miso_sy <= {miso_sy[1:0], spi.miso};
    end
  end

  always_comb begin
    wr = psel && penable && pwrite;
    mapped = paddr == REG_CMD || paddr == REG_ADDR || paddr == REG_DATA
             || paddr == REG_STATUS;
    half = div == 5'(SCK_HALF_CLKS - 1);
    next_miso_q = (miso_sy[2] == miso_sy[1]) ? miso_sy[1] : miso_q;
    next_hs = hs;
    next_op = op;
    next_data_r = wr && paddr == REG_DATA ? pwdata[7:0] : data_r;
    next_addr_r = wr && paddr == REG_ADDR ? pwdata[15:0] : addr_r;
    next_rx = rx;
    next_rxsh = rxsh;
    next_addr_en = addr_en;
    next_data_en = data_en;
    next_rd_n = rd_n;
    next_txsh = txsh;
    next_nbits = nbits;
    next_bitcnt = bitcnt;
    next_div = half ? 5'h00 : div + 5'h01;
    next_sck = sck;
    next_cs_n = cs_n;
    next_mosi = mosi;
    next_prdata = prdata;
    if (psel && !penable) begin
      case (paddr)
        REG_CMD: next_prdata = {19'h0, rd_n, data_en, addr_en, op};
        REG_ADDR: next_prdata = {16'h0, addr_r};
        REG_DATA: next_prdata = {24'h0, rx};
        REG_STATUS: next_prdata = {31'h0, hs != H_IDLE};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
    case (hs)
      H_IDLE: begin
        next_div = 5'h00;
        // Commands written while a frame runs are dropped
        if (wr && paddr == REG_CMD) begin
          next_op = pwdata[CMD_OP_LSB +: 8];
          next_addr_en = pwdata[CMD_ADDR_BIT];
          next_data_en = pwdata[CMD_DATA_BIT];
          next_rd_n = pwdata[CMD_RD_LSB +: 3];
          next_txsh = {pwdata[CMD_OP_LSB +: 8], 24'h000000};
          if (pwdata[CMD_ADDR_BIT]) begin
            next_txsh[23:0] = {addr_r, data_r};
          end else begin
            next_txsh[23:16] = data_r;
          end
          next_nbits = 7'h08 + (pwdata[CMD_ADDR_BIT] ? 7'h10 : 7'h00)
                       + (pwdata[CMD_DATA_BIT] ? 7'h08 : 7'h00)
                       + {1'b0, pwdata[CMD_RD_LSB +: 3], 3'b000};
          next_bitcnt = 7'h00;
          next_cs_n = 1'b0;
          next_mosi = pwdata[CMD_OP_LSB + 7];
          next_hs = H_RUN;
        end
      end
      H_RUN: begin
        if (half && !sck) begin
          // Mode 0: sample on the rising edge
          next_sck = 1'b1;
          next_rxsh = {rxsh[6:0], miso_q};
          next_bitcnt = bitcnt + 7'h01;
        end else if (half) begin
          next_sck = 1'b0;
          if (bitcnt == nbits) begin
            next_hs = H_TAIL;
          end else begin
            next_txsh = {txsh[30:0], 1'b0};
            next_mosi = txsh[30];
          end
        end
      end
      H_TAIL: begin
        // deselect only after a whole byte
        if (half) begin
          next_cs_n = 1'b1;
          next_rx = rxsh;
          next_hs = H_GAP;
        end
      end
      H_GAP: begin
        // deselect gap lets the far end see select high
        if (half) begin
          next_hs = H_IDLE;
        end
      end
      default: next_hs = H_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      hs <= H_IDLE;
      op <= BYTE_RESET;
      data_r <= BYTE_RESET;
      rx <= BYTE_RESET;
      rxsh <= BYTE_RESET;
      addr_r <= ADDR_RESET;
      addr_en <= 1'b0;
      data_en <= 1'b0;
      rd_n <= 3'h0;
      txsh <= 32'h0000_0000;
      nbits <= 7'h00;
      bitcnt <= 7'h00;
      div <= 5'h00;
      sck <= 1'b0;
      cs_n <= 1'b1;
      mosi <= 1'b0;
      miso_q <= 1'b1;
      prdata <= 32'h0000_0000;
    end else begin
      hs <= next_hs;
      op <= next_op;
      data_r <= next_data_r;
      rx <= next_rx;
      rxsh <= next_rxsh;
      addr_r <= next_addr_r;
      addr_en <= next_addr_en;
      data_en <= next_data_en;
      rd_n <= next_rd_n;
      txsh <= next_txsh;
      nbits <= next_nbits;
      bitcnt <= next_bitcnt;
      div <= next_div;
      sck <= next_sck;
      cs_n <= next_cs_n;
      mosi <= next_mosi;
      miso_q <= next_miso_q;
      prdata <= next_prdata;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign spi.cs_n = cs_n;
  assign spi.sck = sck;
  assign spi.mosi = mosi;
endmodule : idl_spi_host

// *** verification/idl_link_monitor.sv ***
// Link checker for the ident-page lock memory end and its host
`timescale 1ns/1ns
module idl_link_monitor #(
  parameter int unsigned WRITE_CYCLES = 50
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic miso,
  input wire logic write_busy_flag,
  input wire logic ident_locked
);
  logic [31:0] busy_cnt;
  logic [31:0] next_busy_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Length of the write cycle, counted since a repetition would be huge
  always_comb begin
    next_busy_cnt = (rstn && write_busy_flag) ? busy_cnt + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk) begin
    busy_cnt <= next_busy_cnt;
  end
  property p_sel_release;
    cs_n [*6] |-> !miso_oe;
  endproperty
  a_sel_release: assert property (p_sel_release) else $error("drive kept");
  property p_drive_start;
    $rose(miso_oe) |-> !cs_n && !sck;
  endproperty
  a_drive_start: assert property (p_drive_start) else $error("bad drive");
  property p_idle_high;
    !miso_oe |-> miso;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line not high");
  property p_reset_state;
    $rose(rstn) |-> (!miso_oe && !write_busy_flag) [*3];
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("not idle");
  property p_busy_len;
    $fell(write_busy_flag) |->
      busy_cnt >= WRITE_CYCLES && busy_cnt <= WRITE_CYCLES + 1;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length");
  property p_busy_desel;
    $rose(write_busy_flag) |-> cs_n;
  endproperty
  a_busy_desel: assert property (p_busy_desel) else $error("busy start");
  property p_lock_sticky;
    ident_locked |=> ident_locked;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock lost");
  property p_lock_start;
    $rose(ident_locked) |-> write_busy_flag;
  endproperty
  a_lock_start: assert property (p_lock_start) else $error("lock no cycle");
  property p_bit_hold;
    miso_oe && $rose(sck) |-> $stable(miso_o) [*8];
  endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("bit moved");
  property p_sck_idle;
    cs_n |-> !sck;
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("clock not idle");
  property p_drop_desel;
    $fell(miso_oe) |-> cs_n;
  endproperty
  a_drop_desel: assert property (p_drop_desel) else $error("early drop");
  // host data held for eight clocks after each clock rise inside a frame
  property p_mosi_hold;
    !cs_n && $rose(sck) |-> $stable(mosi) [*8];
  endproperty
  a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved");
endmodule : idl_link_monitor

// *** verification/id_page_lock_and_power_state_tb_top.sv ***
// Bench: host and memory end on one link, a second end bit-banged
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module id_page_lock_and_power_state_tb_top import idl_pkg::*;;
  localparam int unsigned WCYC = 3000;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, e;
  logic busy, locked, busy2, locked2, sck_q;
  logic [15:0] ad;
  logic [32:0] a;
  logic [2:0] bitn;
  logic [7:0] sh_o, sh_i;
  logic [31:0] wire_q[$];
  logic [32:0] apb_q[$];
  logic [31:0] seed = 32'h0000_2CF6;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;
  idl_spi_if spi();
  idl_spi_if spi2();
  idl_spi_host idl_spi_host_inst (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .spi(spi.host));
  idl_eeprom_dev #(.WRITE_CYCLES(WCYC)) idl_eeprom_dev_inst (.clk(clk),
    .rstn(rstn), .spi(spi.dev), .write_busy_flag(busy),
    .ident_locked(locked));
  idl_eeprom_dev #(.WRITE_CYCLES(WCYC)) idl_eeprom_dev_inst2 (.clk(clk),
    .rstn(rstn), .spi(spi2.dev), .write_busy_flag(busy2),
    .ident_locked(locked2));
  idl_link_monitor #(.WRITE_CYCLES(WCYC)) idl_link_monitor_inst (
    .clk(clk), .rstn(rstn), .cs_n(spi.cs_n), .sck(spi.sck),
    .mosi(spi.mosi), .miso_o(spi.miso_o), .miso_oe(spi.miso_oe),
    .miso(spi.miso), .write_busy_flag(busy), .ident_locked(locked));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task final_report;
    if (fail_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  // Hang guard well above the longest expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      fail_count++;
      final_report();
    end
  end
  // wire bytes, mosi and miso together, MSB first
  always @(posedge clk) begin
    if (spi.cs_n) begin
      bitn = 3'h0;
    end else if (!sck_q && spi.sck) begin
      sh_o = {sh_o[6:0], spi.mosi};
      sh_i = {sh_i[6:0], spi.miso};
      if (bitn == 3'h7) begin
        e = (wire_q.size() > 0) ? wire_q.pop_front() : 32'hFFFF_0F0F;
        `CHK({sh_o, sh_i} & e[31:16], e[15:0])
      end
      bitn = bitn + 3'h1;
    end
    sck_q = spi.sck;
  end
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready === 1'b1 && apb_q.size() > 0)
    begin
      a = apb_q.pop_front();
      `CHK({pslverr, prdata}, a)
    end
  end
  task apb(input logic w, input logic [7:0] ad_r, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad_r;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [7:0] ad_r, input logic [32:0] ex);
    apb_q.push_back(ex);
    apb(1'b0, ad_r, 32'h0);
  endtask : rd
  // Host frame; read bytes compare miso only, mosi there is unspecified
  task frame(input logic [7:0] op, input logic [15:0] fa, input logic ae,
             input logic [7:0] dt, input logic de, input logic [2:0] nr,
             input logic [7:0] rv);
    int i;
    wire_q.push_back({16'hFFFF, op, 8'hFF});
    if (ae) wire_q.push_back({16'hFFFF, fa[15:8], 8'hFF});
    if (ae) wire_q.push_back({16'hFFFF, fa[7:0], 8'hFF});
    if (de) wire_q.push_back({16'hFFFF, dt, 8'hFF});
    for (i = 0; i < nr; i++) wire_q.push_back({16'h00FF, 8'h00, rv});
    apb(1'b1, REG_ADDR, {16'h0, fa});
    apb(1'b1, REG_DATA, {24'h0, dt});
    apb(1'b1, REG_CMD, {19'h0, nr, de, ae, op});
    @(posedge clk);
    while (spi.cs_n !== 1'b1) @(posedge clk);
    repeat (20) @(posedge clk);
  endtask : frame
  // Bit-banged frame on the second link, 160 ns clock, only inside frames
  task bb(input logic [39:0] v, input int n);
    int i;
    @(posedge clk);
    spi2.cs_n <= 1'b0;
    for (i = n - 1; i >= 0; i--) begin
      spi2.mosi <= v[i];
      repeat (8) @(posedge clk);
      spi2.sck <= 1'b1;
      repeat (8) @(posedge clk);
      spi2.sck <= 1'b0;
    end
    repeat (8) @(posedge clk);
    spi2.cs_n <= 1'b1;
    repeat (20) @(posedge clk);
  endtask : bb
  initial begin
    rstn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    spi2.cs_n = 1'b1;
    spi2.sck = 1'b0;
    spi2.mosi = 1'b0;
    sck_q = 1'b0;
    bitn = 3'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    rd(REG_STATUS, 33'h0);
    rd(8'h10, {1'b1, 32'h0});
    r = xs();
    ad = (r[15:0] & 16'hFBFF) | 16'h0400;
    frame(READ_LOCK_STATE_CMD, ad, 1'b1, 8'h00, 1'b0, 3'h3, 8'h00);
    rd(REG_DATA, 33'h0);
    // byte write keeps the rest of its group
    frame(WRITE_ENABLE_CMD, 16'h0, 1'b0, 8'h00, 1'b0, 3'h0, 8'h00);
    frame(WRITE_IDENT_PAGE_CMD, 16'h0001, 1'b1, r[7:0], 1'b1, 3'h0, 8'h00);
    while (busy !== 1'b0) @(posedge clk);
    frame(READ_IDENT_PAGE_CMD, 16'h0001, 1'b1, 8'h00, 1'b0, 3'h1, r[7:0]);
    frame(READ_IDENT_PAGE_CMD, 16'h0002, 1'b1, 8'h00, 1'b0, 3'h2, 8'hFF);
    frame(LOCK_IDENT_PAGE_CMD, ad, 1'b1, r[23:16] | 8'h02, 1'b1, 3'h0, 8'h00);
    `CHK(locked, 1'b0)
    frame(WRITE_ENABLE_CMD, 16'h0, 1'b0, 8'h00, 1'b0, 3'h0, 8'h00);
    frame(LOCK_IDENT_PAGE_CMD, ad, 1'b1, r[31:24] & 8'hFD, 1'b1, 3'h0, 8'h00);
    `CHK(locked, 1'b0)
    frame(READ_STATUS_CMD, 16'h0, 1'b0, 8'h00, 1'b0, 3'h1, 8'h00);
    frame(WRITE_ENABLE_CMD, 16'h0, 1'b0, 8'h00, 1'b0, 3'h0, 8'h00);
    frame(READ_STATUS_CMD, 16'h0, 1'b0, 8'h00, 1'b0, 3'h1, 8'h02);
    // valid lock starts the write cycle
    r = xs();
    frame(LOCK_IDENT_PAGE_CMD, ad, 1'b1, r[7:0] | 8'h02, 1'b1, 3'h0, 8'h00);
    `CHK(locked, 1'b1)
    `CHK(busy, 1'b1)
    frame(READ_STATUS_CMD, 16'h0, 1'b0, 8'h00, 1'b0, 3'h1, 8'h01);
    frame(READ_LOCK_STATE_CMD, ad, 1'b1, 8'h00, 1'b0, 3'h1, 8'hFF);
    while (busy !== 1'b0) @(posedge clk);
    ad = (r[31:16] & 16'hFBFF) | 16'h0400;
    frame(READ_LOCK_STATE_CMD, ad, 1'b1, 8'h00, 1'b0, 3'h3, 8'h01);
    rd(REG_DATA, 33'h1);
    frame(WRITE_ENABLE_CMD, 16'h0, 1'b0, 8'h00, 1'b0, 3'h0, 8'h00);
    frame(WRITE_IDENT_PAGE_CMD, r[15:0] & 16'hFBFF, 1'b1, r[7:0], 1'b1,
          3'h0, 8'h00);
    `CHK(busy, 1'b0)
    // reset drops the latch, keeps the lock
    frame(WRITE_ENABLE_CMD, 16'h0, 1'b0, 8'h00, 1'b0, 3'h0, 8'h00);
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK(locked, 1'b1)
    frame(READ_STATUS_CMD, 16'h0, 1'b0, 8'h00, 1'b0, 3'h1, 8'h00);
    bb(40'h06, 8);
    bb({5'h0, 32'h8204_0002, 3'h5}, 35);
    `CHK({locked2, busy2}, 2'b00)
    // full block protect refuses the lock
    bb(40'h06, 8);
    bb(40'h010C, 16);
    while (busy2 !== 1'b0) @(posedge clk);
    bb(40'h06, 8);
    bb(40'h8204_0002, 32);
    `CHK({locked2, busy2}, 2'b00)
    `CHK(wire_q.size(), 0)
    final_report();
  end
endmodule : id_page_lock_and_power_state_tb_top
